// >>> src/power_mode_clock_selector.sv
// Overview of operation
// - halt with halt select 0 enters Sleep; all clocks and gates off
// - source select 00 primary, 01 secondary, 1x internal block
// - halt with halt select 1 enters Idle; cpu stops, peripherals run
// - writing the source select starts a switch at once, no halt needed
// - a switch takes two old-source cycles plus three new ones
// - halt select is sampled at each halt to pick Sleep or Idle
// - each later halt uses the halt select value current at that time
// - primary active flag, bit 3, set while primary clocks the device
// - fast internal flag, bit 2, set while stable 8 MHz internal output clocks the device
// - secondary active flag, bit 6, set while secondary clocks the device
// - all flags clear in internal mode on slow internal clock or unstable fast oscillator
// - only internal-as-primary lets primary and fast flags both be set
// - moving to internal mode clears primary flag when internal is primary
// - reset leaves primary run with primary flag set, unless two-speed start
// - selecting 01 moves to secondary, stops primary, swaps the flags
// - selecting 01 with secondary disabled is refused; clock unchanged
// - peripheral clocks held off until a selected secondary oscillates
// - return to primary keeps secondary clock until primary ready
// - crystal primary waits 1024 oscillator cycles before being ready
// - reset clears halt select so a bare halt means Sleep
module power_mode_clock_selector
  import power_mode_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES
)
(
  input  wire logic                    clk,                  // 40 MHz system clock
  input  wire logic                    rst_b,                // async reset, active low
  input  wire logic                    primaryOsc,           // primary oscillator level
  input  wire logic                    secondaryOsc,         // secondary oscillator level
  input  wire logic                    internalOsc,          // internal block output level
  input  wire logic                    primaryIsCrystal,     // primary config is a crystal
  input  wire logic                    primaryIsInternal,    // primary config is internal
  input  wire logic                    twoSpeedStartup,      // two-speed start-up enable
  input  wire logic                    secondaryOscEnable,   // secondary oscillator enable
  input  wire logic                    secondaryOscRunning,  // secondary is oscillating
  input  wire logic                    fastInternalStable,   // fast internal output stable
  input  wire logic [2:0]              internalFreqSelect,   // 0 means slow internal osc
  input  wire logic                    haltExec,             // halt instruction pulse
  input  wire logic                    wakeEvent,            // wake pulse
  input  wire logic                    haltSelectWr,         // halt select write strobe
  input  wire logic                    haltSelectIn,         // halt select write data
  input  wire logic                    sourceSelectWr,       // source select write strobe
  input  wire logic [1:0]              sourceSelectIn,       // source select write data
  output logic                         deviceClk,            // gated device clock
  output logic                         cpuClk,               // cpu clock
  output logic                         periphClk,            // peripheral clock
  output logic                         primaryOscOn,         // primary oscillator enable
  output logic                         switchBusy,           // source switch in progress
  output logic [STATUS_WIDTH-1:0]      oscCtrlStatus,        // oscillator control image
  output logic [STATUS_WIDTH-1:0]      timerOneStatus        // timer-1 control image
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (STARTUP_COUNT < 1 || STARTUP_COUNT > 65536)
  begin : g_bad_startup
    $error("STARTUP_COUNT must lie in 1..65536");
  end

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  function automatic clk_src_t decodeSource(input logic [1:0] sel);
    if (sel[SEL_INTERNAL_BIT])
      return SRC_INTERNAL;
    else if (sel == SEL_SECONDARY)
      return SRC_SECONDARY;
    else
      return SRC_PRIMARY;
  endfunction

  logic                   cpuHaltSelect;
  logic [1:0]             clockSourceSelect;
  power_state_t           powerState;
  clk_src_t               curSrc;
  clk_src_t               pendSrc;
  switch_state_t          swState;
  logic [1:0]             swCount;
  logic [15:0]            startupCount;
  logic                   primaryReady;
  logic                   startupDone;
  logic                   devGate;
  logic                   cpuGate;
  logic                   periphGate;
  logic                   primaryClockActiveFlag;
  logic                   fastInternalStableFlag;
  logic                   secondaryClockActiveFlag;
  logic [NUM_SOURCES-1:0] oscLevel;
  logic [NUM_SOURCES-1:0] oscRise;
  logic [NUM_SOURCES-1:0] oscFall;

  assign oscLevel = {internalOsc, secondaryOsc, primaryOsc};

  for (genvar i = 0; i < NUM_SOURCES; i++)
  begin : g_edge
    osc_edge_detect u_edge
    (
      .clk      (clk),
      .rst_b    (rst_b),
      .oscLevel (oscLevel[i]),
      .rise     (oscRise[i]),
      .fall     (oscFall[i])
    );
  end

  wire clk_src_t reqSrc      = decodeSource(clockSourceSelect);
  wire clk_src_t wrSrc       = decodeSource(sourceSelectIn);
  wire           asleep      = (powerState == PM_SLEEP);
  wire           selRefused  = (wrSrc == SRC_SECONDARY) && !secondaryOscEnable;
  wire           reqReady    = (reqSrc == SRC_PRIMARY)   ? primaryReady :
                               (reqSrc == SRC_SECONDARY) ? secondaryOscRunning : 1'b1;
  wire           curReady    = (curSrc == SRC_PRIMARY)   ? primaryReady :
                               (curSrc == SRC_SECONDARY) ? secondaryOscRunning : 1'b1;
  wire           curLevel    = oscLevel[curSrc];
  wire           curFall     = oscFall[curSrc];
  wire           pendFall    = oscFall[pendSrc];
  wire           secHold     = (swState == SW_WAIT_READY) && (reqSrc == SRC_SECONDARY)
                               && !secondaryOscRunning;
  // gates skip the start-up edge, where the source may still change; old source runs to its last fall
  wire           follow      = startupDone && !asleep && curReady && (swState != SW_NEW_PHASE);
  wire           intFast     = (internalFreqSelect != 3'h0) && fastInternalStable;
  wire           primDrives  = !asleep && (curSrc == SRC_PRIMARY) && primaryReady;
  wire           secDrives   = !asleep && (curSrc == SRC_SECONDARY);
  wire           fastDrives  = !asleep && intFast &&
                               ((curSrc == SRC_INTERNAL) ||
                                ((curSrc == SRC_PRIMARY) && primaryIsInternal));
  wire           startupLast = (startupCount == 16'(STARTUP_COUNT - 1));

  assign primaryOscOn = !asleep && ((curSrc == SRC_PRIMARY) || (reqSrc == SRC_PRIMARY));
  assign switchBusy   = (swState != SW_STABLE);

  // ----------------------------------------------------------------
  // software-visible control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuHaltSelect     <= 1'b0;
      clockSourceSelect <= SEL_PRIMARY;
    end
    else
    begin
      if (haltSelectWr)
        cpuHaltSelect <= haltSelectIn;
      if (sourceSelectWr && !selRefused)
        clockSourceSelect <= sourceSelectIn;
    end
  end

  // ----------------------------------------------------------------
  // power mode: halt and wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      powerState <= PM_RUN;
    else if (powerState == PM_RUN && haltExec)
      powerState <= cpuHaltSelect ? PM_IDLE : PM_SLEEP;
    else if (powerState != PM_RUN && wakeEvent)
      powerState <= PM_RUN;
  end

  // ----------------------------------------------------------------
  // primary start-up timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primaryReady <= 1'b1;
      startupCount <= 16'h0000;
      startupDone  <= 1'b0;
    end
    else
    begin
      startupDone <= 1'b1;
      if (!startupDone && twoSpeedStartup)
      begin
        primaryReady <= 1'b0;
        startupCount <= 16'h0000;
      end
      else if (!primaryOscOn)
      begin
        primaryReady <= 1'b0;
        startupCount <= 16'h0000;
      end
      else if (!primaryReady && oscRise[SRC_PRIMARY])
      begin
        // non-crystal sources are usable at their first edge
        if (!primaryIsCrystal || startupLast)
          primaryReady <= 1'b1;
        else
          startupCount <= startupCount + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // source switch sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      curSrc  <= SRC_PRIMARY;
      pendSrc <= SRC_PRIMARY;
      swState <= SW_STABLE;
      swCount <= 2'h0;
    end
    else if (!startupDone && twoSpeedStartup)
    begin
      // run from the internal block while the primary starts
      curSrc  <= SRC_INTERNAL;
      swState <= SW_STABLE;
    end
    else if (asleep)
    begin
      swState <= SW_STABLE;
      swCount <= 2'h0;
    end
    else
    begin
      case (swState)
        SW_STABLE:
          if (reqSrc != curSrc)
            swState <= SW_WAIT_READY;
        SW_WAIT_READY:
          if (reqSrc == curSrc)
            swState <= SW_STABLE;
          else if (reqReady)
          begin
            pendSrc <= reqSrc;
            swCount <= 2'h0;
            swState <= SW_OLD_PHASE;
          end
        SW_OLD_PHASE:
          if (curFall)
          begin
            if (swCount == OLD_SRC_CYCLES - 2'h1)
            begin
              swCount <= 2'h0;
              swState <= SW_NEW_PHASE;
            end
            else
              swCount <= swCount + 2'h1;
          end
        SW_NEW_PHASE:
          if (pendFall)
          begin
            if (swCount == NEW_SRC_CYCLES - 2'h1)
            begin
              curSrc  <= pendSrc;
              swCount <= 2'h0;
              swState <= SW_STABLE;
            end
            else
              swCount <= swCount + 2'h1;
          end
        default:
          swState <= SW_STABLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // glitch-free gating
  // ----------------------------------------------------------------
  // gates only change while the selected source is low, so no phase is cut
  wire next_devGate    = curLevel ? devGate : follow;
  wire next_periphGate = curLevel ? periphGate : (follow && !secHold);
  wire next_cpuGate    = curLevel ? cpuGate : (follow && !secHold && powerState == PM_RUN);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      devGate    <= 1'b0;
      periphGate <= 1'b0;
      cpuGate    <= 1'b0;
      deviceClk  <= 1'b0;
      periphClk  <= 1'b0;
      cpuClk     <= 1'b0;
    end
    else
    begin
      devGate    <= next_devGate;
      periphGate <= next_periphGate;
      cpuGate    <= next_cpuGate;
      deviceClk  <= devGate && curLevel;
      periphClk  <= periphGate && curLevel;
      cpuClk     <= cpuGate && curLevel;
    end
  end

  // ----------------------------------------------------------------
  // clock status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primaryClockActiveFlag   <= 1'b1;
      fastInternalStableFlag   <= 1'b0;
      secondaryClockActiveFlag <= 1'b0;
    end
    else
    begin
      primaryClockActiveFlag   <= primDrives;
      fastInternalStableFlag   <= fastDrives;
      secondaryClockActiveFlag <= secDrives;
    end
  end

  always_comb
  begin
    oscCtrlStatus = '0;
    oscCtrlStatus[OSC_HALT_SELECT_BIT]               = cpuHaltSelect;
    oscCtrlStatus[OSC_PRIMARY_FLAG_BIT]              = primaryClockActiveFlag;
    oscCtrlStatus[OSC_FAST_FLAG_BIT]                 = fastInternalStableFlag;
    oscCtrlStatus[OSC_SELECT_LSB +: 2]               = clockSourceSelect;
    timerOneStatus                                   = '0;
    timerOneStatus[TMR1_SECONDARY_FLAG_BIT]          = secondaryClockActiveFlag;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence haltTaken;
    (powerState == PM_RUN) && haltExec;
  endsequence

  sequence oldLastFall;
    startupDone && (swState == SW_OLD_PHASE) && !asleep && curFall && (swCount == 2'h1);
  endsequence

  sequence newLastFall;
    startupDone && (swState == SW_NEW_PHASE) && !asleep && pendFall && (swCount == 2'h2);
  endsequence

  halt_mode_pick_a: assert property (haltTaken |=>
    powerState == ($past(cpuHaltSelect) ? PM_IDLE : PM_SLEEP))
    else $error("halt did not follow halt select");

  sleep_clocks_off_a: assert property ((asleep && !devGate) |=>
    !deviceClk && !cpuClk && !periphClk)
    else $error("clock active in sleep");

  sleep_flags_clear_a: assert property (asleep |=>
    !primaryClockActiveFlag && !fastInternalStableFlag && !secondaryClockActiveFlag)
    else $error("status flag set in sleep");

  idle_cpu_off_a: assert property ((powerState == PM_IDLE && !curLevel) |=>
    !cpuGate ##1 !cpuClk)
    else $error("cpu clock gate open in idle");

  secondary_refused_a: assert property ((sourceSelectWr && selRefused) |=>
    $stable(clockSourceSelect))
    else $error("refused select was stored");

  old_phase_end_a: assert property (oldLastFall |=>
    swState == SW_NEW_PHASE && swCount == 2'h0)
    else $error("old source phase length wrong");

  new_phase_end_a: assert property (newLastFall |=>
    swState == SW_STABLE && curSrc == $past(pendSrc))
    else $error("new source phase length wrong");

  peripheral_hold_a: assert property ((secHold && !asleep && !curLevel) |=>
    !periphGate)
    else $error("peripheral clock ran before secondary started");

  secondary_flag_a: assert property (secondaryClockActiveFlag |->
    $past(secDrives) && !primaryClockActiveFlag)
    else $error("secondary flag without secondary clock");

endmodule // power_mode_clock_selector

// >>> src/power_mode_pkg.sv
package power_mode_pkg;

  // ----------------------------------------------------------------
  // clock sources, modes and switch phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} clk_src_t;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} power_state_t;
  typedef enum logic [1:0] {SW_STABLE, SW_WAIT_READY, SW_OLD_PHASE, SW_NEW_PHASE} switch_state_t;

  // ----------------------------------------------------------------
  // select field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_PRIMARY      = 2'h0;
  localparam logic [1:0] SEL_SECONDARY    = 2'h1;
  localparam int         SEL_INTERNAL_BIT = 1;

  // ----------------------------------------------------------------
  // status bit positions in the two control register images
  // ----------------------------------------------------------------
  localparam int OSC_HALT_SELECT_BIT     = 7;
  localparam int OSC_PRIMARY_FLAG_BIT    = 3;
  localparam int OSC_FAST_FLAG_BIT       = 2;
  localparam int OSC_SELECT_LSB          = 0;
  localparam int TMR1_SECONDARY_FLAG_BIT = 6;
  localparam int STATUS_WIDTH            = 8;

  // ----------------------------------------------------------------
  // timing counts in source cycles, plus source count and clock figures
  // ----------------------------------------------------------------
  localparam int         STARTUP_CYCLES    = 1024;
  localparam logic [1:0] OLD_SRC_CYCLES    = 2'h2;
  localparam logic [1:0] NEW_SRC_CYCLES    = 2'h3;
  localparam int         NUM_SOURCES       = 3;
  localparam int         CLK_PERIOD_NS     = 25;
  localparam int         FAST_INTERNAL_MHZ = 8;

endpackage

// >>> src/osc_edge_detect.sv
module osc_edge_detect
(
  input  wire logic clk,       // system clock
  input  wire logic rst_b,     // async reset, active low
  input  wire logic oscLevel,  // sampled oscillator level
  output logic      rise,      // one-cycle pulse on a low-to-high step
  output logic      fall       // one-cycle pulse on a high-to-low step
);

  logic prevLevel;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevLevel <= 1'b0;
    end
    else
    begin
      prevLevel <= oscLevel;
    end
  end

  assign rise = oscLevel & ~prevLevel;
  assign fall = ~oscLevel & prevLevel;

endmodule // osc_edge_detect

// >>> test/cpu_osc_model.sv
module cpu_osc_model
(
  input  wire logic       clk,                 // system clock
  input  wire logic       rst_b,               // async reset, active low
  input  wire logic       primaryOscOn,        // primary enable
  input  wire logic       secondaryOscEnable,  // secondary enable
  output logic            primaryOsc,          // primary level
  output logic            secondaryOsc,        // secondary level
  output logic            internalOsc,         // internal level
  output logic            secondaryOscRunning, // secondary oscillating
  output logic            haltExec,            // halt pulse
  output logic            wakeEvent,           // wake pulse
  output logic            haltSelectWr,        // halt select strobe
  output logic            haltSelectIn,        // halt select data
  output logic            sourceSelectWr,      // source select strobe
  output logic [1:0]      sourceSelectIn       // source select data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] pCnt;
  logic [3:0] sCnt;
  logic [3:0] iCnt;
  logic [5:0] startCnt;
  logic [3:0] strobe;

  assign {sourceSelectWr, haltSelectWr, wakeEvent, haltExec} = strobe;

  // ------------------------------------------------------------
  // oscillators
  // ------------------------------------------------------------
  // a stopped oscillator sits low, it does not keep a half period
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pCnt <= 4'h0;
      sCnt <= 4'h0;
      iCnt <= 4'h0;
      startCnt <= 6'h0;
      primaryOsc <= 1'b0;
      secondaryOsc <= 1'b0;
      internalOsc <= 1'b0;
      secondaryOscRunning <= 1'b0;
    end
    else
    begin
      pCnt <= primaryOscOn ? pCnt + 4'h1 : 4'h0;
      sCnt <= secondaryOscRunning ? sCnt + 4'h1 : 4'h0;
      iCnt <= iCnt + 4'h1;
      primaryOsc <= pCnt[1];
      secondaryOsc <= sCnt[2];
      internalOsc <= iCnt[1];
      // slow start-up after enable, so early selection is visible
      startCnt <= !secondaryOscEnable ? 6'h0 :
                  (startCnt == 6'h28) ? startCnt : startCnt + 6'h1;
      secondaryOscRunning <= (startCnt == 6'h28);
    end
  end

  // ------------------------------------------------------------
  // cpu side: one-cycle strobes with their data
  // ------------------------------------------------------------
  initial
  begin
    strobe = 4'h0;
    haltSelectIn = 1'b0;
    sourceSelectIn = 2'h0;
  end

  task automatic op(input logic [3:0] s, input logic [1:0] v);
    @(posedge clk);
    strobe <= s;
    sourceSelectIn <= v;
    haltSelectIn <= v[0];
    @(posedge clk);
    strobe <= 4'h0;
  endtask
endmodule // cpu_osc_model

// >>> test/tb_power_mode_clock_selector.sv
module tb_power_mode_clock_selector;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] freq;
    logic       pInt;
    logic [7:0] osc;
    logic [7:0] t1;
  } row_t;

  localparam logic [3:0] HALT = 4'h1;
  localparam logic [3:0] WAKE = 4'h2;
  localparam logic [3:0] HSEL = 4'h4;
  localparam logic [3:0] SSEL = 4'h8;

  logic       clk, rst_b, primaryOsc, secondaryOsc, internalOsc, primaryIsInternal;
  logic       secondaryOscEnable, secondaryOscRunning, fastInternalStable, twoSpeed;
  logic       haltExec, wakeEvent, haltSelectWr, haltSelectIn, sourceSelectWr;
  logic       deviceClk, cpuClk, periphClk, primaryOscOn, switchBusy;
  logic [1:0] sourceSelectIn;
  logic [2:0] internalFreqSelect, on;
  logic [7:0] oscCtrlStatus, timerOneStatus;
  int         miscompares, cmpCount, cycles;
  row_t       rows [7] = '{
    {2'h1, 3'h6, 1'h0, 8'h01, 8'h40}, {2'h0, 3'h6, 1'h0, 8'h08, 8'h00},
    {2'h2, 3'h6, 1'h0, 8'h06, 8'h00}, {2'h3, 3'h0, 1'h0, 8'h03, 8'h00},
    {2'h0, 3'h6, 1'h1, 8'h0C, 8'h00}, {2'h2, 3'h6, 1'h1, 8'h06, 8'h00},
    {2'h0, 3'h6, 1'h0, 8'h08, 8'h00}};

  power_mode_clock_selector #(.STARTUP_COUNT(4)) u_power_mode_clock_selector (
    .clk(clk), .rst_b(rst_b), .primaryOsc(primaryOsc), .secondaryOsc(secondaryOsc),
    .internalOsc(internalOsc), .primaryIsCrystal(!primaryIsInternal),
    .primaryIsInternal(primaryIsInternal), .twoSpeedStartup(twoSpeed),
    .secondaryOscEnable(secondaryOscEnable), .secondaryOscRunning(secondaryOscRunning),
    .fastInternalStable(fastInternalStable), .internalFreqSelect(internalFreqSelect),
    .haltExec(haltExec), .wakeEvent(wakeEvent), .haltSelectWr(haltSelectWr),
    .haltSelectIn(haltSelectIn), .sourceSelectWr(sourceSelectWr),
    .sourceSelectIn(sourceSelectIn), .deviceClk(deviceClk), .cpuClk(cpuClk),
    .periphClk(periphClk), .primaryOscOn(primaryOscOn), .switchBusy(switchBusy),
    .oscCtrlStatus(oscCtrlStatus), .timerOneStatus(timerOneStatus));

  cpu_osc_model u_cpu_osc_model (
    .clk(clk), .rst_b(rst_b), .primaryOscOn(primaryOscOn),
    .secondaryOscEnable(secondaryOscEnable), .primaryOsc(primaryOsc),
    .secondaryOsc(secondaryOsc), .internalOsc(internalOsc),
    .secondaryOscRunning(secondaryOscRunning), .haltExec(haltExec),
    .wakeEvent(wakeEvent), .haltSelectWr(haltSelectWr), .haltSelectIn(haltSelectIn),
    .sourceSelectWr(sourceSelectWr), .sourceSelectIn(sourceSelectIn));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // which of {device, cpu, periph} clocks moved within n cycles
  task automatic activity(input int n, output logic [2:0] act);
    logic [2:0] last;
    act = 3'h0;
    last = {deviceClk, cpuClk, periphClk};
    repeat (n)
    begin
      @(negedge clk);
      act = act | (last ^ {deviceClk, cpuClk, periphClk});
      last = {deviceClk, cpuClk, periphClk};
    end
  endtask

  task automatic settle();
    int k;
    k = 0;
    repeat (2) @(negedge clk);
    while (switchBusy !== 1'b0 && k < 600)
    begin
      @(negedge clk);
      k++;
    end
    check(k < 600, 1);
    repeat (3) @(negedge clk);
  endtask

  task automatic halt_and_watch(input logic [2:0] exp);
    u_cpu_osc_model.op(HALT, 2'h0);
    repeat (10) @(negedge clk);
    activity(30, on);
    check(on, exp);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    primaryIsInternal = 1'b0;
    twoSpeed = 1'b0;
    secondaryOscEnable = 1'b1;
    fastInternalStable = 1'b1;
    internalFreqSelect = 3'h6;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    check(oscCtrlStatus, 8'h08);
    check(timerOneStatus, 8'h00);
    activity(40, on);
    check(on, 3'h7);
    foreach (rows[i])
    begin
      @(posedge clk);
      primaryIsInternal <= rows[i].pInt;
      internalFreqSelect <= rows[i].freq;
      u_cpu_osc_model.op(SSEL, rows[i].sel);
      settle();
      check(oscCtrlStatus, rows[i].osc);
      check(timerOneStatus, rows[i].t1);
    end
    halt_and_watch(3'h0);
    check({oscCtrlStatus, 7'h0, primaryOscOn}, 16'h0);
    u_cpu_osc_model.op(WAKE, 2'h0);
    settle();
    u_cpu_osc_model.op(HSEL, 2'h1);
    halt_and_watch(3'h5);
    check(oscCtrlStatus, 8'h88);
    u_cpu_osc_model.op(WAKE, 2'h0);
    settle();
    u_cpu_osc_model.op(HSEL, 2'h0);
    halt_and_watch(3'h0);
    u_cpu_osc_model.op(WAKE, 2'h0);
    settle();
    check(oscCtrlStatus, 8'h00);
    repeat (20) @(negedge clk);
    check(oscCtrlStatus, 8'h08);
    @(posedge clk);
    secondaryOscEnable <= 1'b0;
    u_cpu_osc_model.op(SSEL, 2'h1);
    settle();
    check({oscCtrlStatus, timerOneStatus}, 16'h0800);
    @(posedge clk);
    secondaryOscEnable <= 1'b1;
    u_cpu_osc_model.op(SSEL, 2'h1);
    repeat (6) @(negedge clk);
    activity(20, on);
    check(on[0], 1'b0);
    settle();
    activity(30, on);
    check(on, 3'h7);
    check({oscCtrlStatus, timerOneStatus}, 16'h0140);
    // second reset with halt select set and two-speed start-up on
    u_cpu_osc_model.op(HSEL, 2'h1);
    @(posedge clk);
    twoSpeed <= 1'b1;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    check(oscCtrlStatus, 8'h04);
    settle();
    check({oscCtrlStatus, timerOneStatus}, 16'h0800);
    give_verdict();
  end
endmodule // tb_power_mode_clock_selector
